// [logic/redundant_io_voter.v]
// redundant_io_voter.v: triple-redundant input voting, fault-tolerant
// output staging, output voting and timed i/o shutdown.
// assumes inputs synchronous to i_clk and an avalon-mm master.
//
// How it works
// [RULE1] discrete bits voted two out of three
// [RULE2] single-block group passes its value unchanged
// [RULE3] discrete copy disagreeing with agreeing pair flagged
// [RULE4] analog copy off mid-value by percent flagged
// [RULE5] fault register names the disagreeing copy
// [RULE6] faulted copies are excluded from voting; analog voting ignores i_autotest_fault
// [RULE7] degrade 3-2-1-0 or 3-2-default per configuration
// [RULE8] three analog copies give the middle value
// [RULE9] two analog copies give high, low or average
// [RULE10] one analog copy is used directly
// [RULE11] vote before each cycle, raw copies readable
// [RULE12] logic outputs copied; only copy drives outputs
// [RULE13] each scan sends non-voted and fault-tolerant outputs
// [RULE14] unrepaired fault forces outputs off, inputs default; the voted analog input is not defaulted and aflag_ff does not start the timer
// [RULE15] shutdown delay from writable autotest interval
// [RULE16] pending shutdown visible, inhibit control accepted
// [RULE17] three commands voted two out of three
// [RULE18] two commands use 1-of-2 or 2-of-2
// [RULE19] single command followed or defaulted off
// [RULE20] sixteen or thirty-two output points per group
// [RULE21] reset clears state, outputs off until vote
//
// Design decisions made here: register access over Avalon-MM and the placing of the registers.
`timescale 1ns/1ns
`include "io_voter_defs.vh"
`default_nettype none

module redundant_io_voter #(
  parameter TICK_CYCLES = `TICK_CYCLES
) (
  input wire i_clk,
  input wire i_resetn,
  input wire [6:0] i_address,
  input wire i_read,
  input wire i_write,
  input wire [31:0] i_writedata,
  input wire [3:0] i_byteenable,
  output reg [31:0] o_readdata,
  output reg o_waitrequest,
  input wire i_cycle_start,
  input wire i_bus_scan,
  input wire [2:0] i_copy_present,
  input wire [2:0] i_autotest_fault,
  input wire [2:0] i_block_fault,
  input wire [31:0] i_din_a,
  input wire [31:0] i_din_b,
  input wire [31:0] i_din_c,
  input wire [15:0] i_ain_a,
  input wire [15:0] i_ain_b,
  input wire [15:0] i_ain_c,
  input wire [2:0] i_cmd_present,
  input wire [31:0] i_cmd_a,
  input wire [31:0] i_cmd_b,
  input wire [31:0] i_cmd_c,
  output reg [31:0] o_voted_di,
  output reg [15:0] o_voted_ai,
  output reg o_vote_done,
  output reg [31:0] o_tx_nonvoted,
  output reg [31:0] o_tx_ft,
  output reg o_tx_valid,
  output reg [31:0] o_phys_out,
  output reg o_shutdown_pending,
  output reg o_shutdown_active
);

  // ----------------------------------------------------------------
  // helper functions
  // ----------------------------------------------------------------
  function [1:0] cnt3;
    input [2:0] v;
    begin
      cnt3 = {1'b0, v[0]} + {1'b0, v[1]} + {1'b0, v[2]};
    end
  endfunction

  function [15:0] med3;
    input [15:0] a;
    input [15:0] b;
    input [15:0] c;
    begin
      if ((a >= b && a <= c) || (a <= b && a >= c))
        med3 = a;
      else if ((b >= a && b <= c) || (b <= a && b >= c))
        med3 = b;
      else
        med3 = c;
    end
  endfunction

  // deviation of x from m above thresh percent of m
  function deviates;
    input [15:0] x;
    input [15:0] m;
    input [6:0] t;
    reg [15:0] d;
    begin
      d = (x > m) ? (x - m) : (m - x);
      deviates = ({8'h00, d} * 24'd100) > ({17'h00000, t} * {8'h00, m});
    end
  endfunction

  function [31:0] bemask;
    input [31:0] old;
    input [31:0] wd;
    input [3:0] be;
    integer k;
    begin
      bemask = old;
      for (k = 0; k < 4; k = k + 1)
        if (be[k])
          bemask[k*8 +: 8] = wd[k*8 +: 8];
    end
  endfunction

  // pick the one set copy out of three
  function [31:0] pick32;
    input [2:0] v;
    input [31:0] a;
    input [31:0] b;
    input [31:0] c;
    begin
      pick32 = v[0] ? a : (v[1] ? b : c);
    end
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  reg [`CTRL_WIDTH-1:0] ctrl_ff;
  reg [31:0] def_in_ff;
  reg [15:0] ana_def_ff;
  reg [6:0] thresh_ff;
  reg [31:0] interval_ff;
  reg [2:0] dflag_ff;
  reg [2:0] aflag_ff;
  reg [2:0] last_copy_ff;
  reg last_analog_ff;
  reg [31:0] logic_out_ff;
  reg [31:0] nv_out_ff;
  reg [31:0] ft_out_ff;
  reg [31:0] tick_cnt_ff;
  reg [31:0] sd_cnt_ff;
  reg [31:0] nxt_voted_di;
  reg [15:0] nxt_voted_ai;
  reg [31:0] nxt_phys;
  reg [31:0] nxt_rdata;

  wire bus_req = i_read | i_write;
  wire wr_commit = i_write & ~o_waitrequest;
  wire rd_launch = i_read & o_waitrequest;
  wire [31:0] ctrl_word = {{(32-`CTRL_WIDTH){1'b0}}, ctrl_ff};
  wire chk_en = ctrl_ff[`CTRL_CHK_EN];
  wire deg_def = ctrl_ff[`CTRL_DEG_DEF];
  wire [1:0] amode = ctrl_ff[`CTRL_AMODE_HI:`CTRL_AMODE_LO];
  wire grp32 = ctrl_ff[`CTRL_GRP32];
  wire [31:0] point_mask = grp32 ? 32'hFFFFFFFF : 32'h0000FFFF; // RULE20

  // ----------------------------------------------------------------
  // copy validity and discrete voting
  // ----------------------------------------------------------------
  wire [2:0] dvalid = i_copy_present & ~dflag_ff & ~i_autotest_fault &
                      ~i_block_fault; // RULE6
  wire [2:0] avalid = i_copy_present & ~aflag_ff & ~i_block_fault; // RULE6
  wire [1:0] dcnt = cnt3(dvalid);
  wire [1:0] acnt = cnt3(avalid);
  wire single_blk = (cnt3(i_copy_present) == 2'h1);

  wire [31:0] maj = (i_din_a & i_din_b) | (i_din_b & i_din_c) |
                    (i_din_a & i_din_c);
  wire [31:0] two_x = dvalid[0] ? i_din_a : i_din_b;
  wire [31:0] two_y = dvalid[2] ? i_din_c : i_din_b;
  wire [31:0] one_d = pick32(dvalid, i_din_a, i_din_b, i_din_c);

  // discrete discrepancy: one copy against an agreeing pair
  wire [2:0] ddisc;
  assign ddisc[0] = |((i_din_a ^ i_din_b) & ~(i_din_b ^ i_din_c)); // RULE3
  assign ddisc[1] = |((i_din_b ^ i_din_a) & ~(i_din_a ^ i_din_c)); // RULE3
  assign ddisc[2] = |((i_din_c ^ i_din_a) & ~(i_din_a ^ i_din_b)); // RULE3
  wire [2:0] dset = (i_cycle_start && chk_en && dvalid == 3'h7) ?
                    ddisc : 3'h0;

  always @*
  begin
    if (o_shutdown_active)
      nxt_voted_di = def_in_ff; // RULE14
    else if (single_blk && dcnt == 2'h1)
      nxt_voted_di = one_d; // RULE2
    else
      case (dcnt)
        2'h3: nxt_voted_di = maj; // RULE1
        // two copies: agreeing bits pass, split bits take the default
        2'h2: nxt_voted_di = (two_x & two_y) |
                             (~(two_x ^ two_y) & 32'h0) |
                             ((two_x ^ two_y) & def_in_ff); // RULE1
        2'h1: nxt_voted_di = deg_def ? def_in_ff : one_d; // RULE7
        default: nxt_voted_di = def_in_ff; // RULE7
      endcase
  end

  // ----------------------------------------------------------------
  // analog voting
  // ----------------------------------------------------------------
  wire [15:0] mid = med3(i_ain_a, i_ain_b, i_ain_c); // RULE8
  wire [15:0] ana_x = avalid[0] ? i_ain_a : i_ain_b;
  wire [15:0] ana_y = avalid[2] ? i_ain_c : i_ain_b;
  wire [16:0] ana_sum = {1'b0, ana_x} + {1'b0, ana_y};
  wire [15:0] ana_one = avalid[0] ? i_ain_a : (avalid[1] ? i_ain_b : i_ain_c);
  wire [2:0] adisc;
  genvar g;
  generate
    for (g = 0; g < 3; g = g + 1)
    begin : g_adisc
      wire [15:0] samp = (g == 0) ? i_ain_a : ((g == 1) ? i_ain_b : i_ain_c);
      assign adisc[g] = deviates(samp, mid, thresh_ff); // RULE4
    end
  endgenerate
  wire [2:0] aset = (i_cycle_start && chk_en && avalid == 3'h7) ?
                    adisc : 3'h0;

  always @*
  begin
    case (acnt)
      2'h3: nxt_voted_ai = mid; // RULE8
      2'h2:
        case (amode)
          `AMODE_LOW: nxt_voted_ai = (ana_x < ana_y) ? ana_x : ana_y; // RULE9
          `AMODE_AVG: nxt_voted_ai = ana_sum[16:1]; // RULE9
          default: nxt_voted_ai = (ana_x > ana_y) ? ana_x : ana_y; // RULE9
        endcase
      2'h1: nxt_voted_ai = (deg_def && !single_blk) ? ana_def_ff :
                           ana_one; // RULE10
      default: nxt_voted_ai = ana_def_ff; // RULE7
    endcase
  end

  // ----------------------------------------------------------------
  // output voter
  // ----------------------------------------------------------------
  wire [31:0] cmaj = (i_cmd_a & i_cmd_b) | (i_cmd_b & i_cmd_c) |
                     (i_cmd_a & i_cmd_c);
  wire [31:0] c_x = i_cmd_present[0] ? i_cmd_a : i_cmd_b;
  wire [31:0] c_y = i_cmd_present[2] ? i_cmd_c : i_cmd_b;
  wire [31:0] c_one = pick32(i_cmd_present, i_cmd_a, i_cmd_b, i_cmd_c);

  always @*
  begin
    case (cnt3(i_cmd_present))
      2'h3: nxt_phys = cmaj; // RULE17
      2'h2: nxt_phys = ctrl_ff[`CTRL_OUT_2OF2] ? (c_x & c_y) :
                       (c_x | c_y); // RULE18
      2'h1: nxt_phys = ctrl_ff[`CTRL_ONE_DEF] ? 32'h0 : c_one; // RULE19
      default: nxt_phys = 32'h0;
    endcase
    // only the fault-tolerant copy may turn a point on
    nxt_phys = nxt_phys & ft_out_ff & point_mask; // RULE12 RULE20
    if (o_shutdown_active)
      nxt_phys = 32'h0; // RULE14
  end

  // ----------------------------------------------------------------
  // shutdown timer
  // ----------------------------------------------------------------
  wire any_fault = |(dflag_ff | i_autotest_fault | i_block_fault) &
                   ~single_blk;
  wire ms_tick = (tick_cnt_ff == TICK_CYCLES - 1);
  wire [33:0] sd_limit = {2'h0, interval_ff} * `SD_INTERVALS; // RULE15
  wire sd_expired = ({2'h0, sd_cnt_ff} >= sd_limit);

  // ----------------------------------------------------------------
  // register read mux
  // ----------------------------------------------------------------
  always @*
  begin
    case (i_address)
      `REG_CTRL: nxt_rdata = ctrl_word;
      `REG_DEF_IN: nxt_rdata = def_in_ff;
      `REG_ANA_DEF: nxt_rdata = {16'h0000, ana_def_ff};
      `REG_THRESH: nxt_rdata = {25'h0000000, thresh_ff};
      `REG_INTERVAL: nxt_rdata = interval_ff;
      `REG_STATUS: nxt_rdata = {20'h00000, o_shutdown_active,
                                o_shutdown_pending, acnt, dcnt, avalid,
                                dvalid}; // RULE16
      `REG_FAULT: nxt_rdata = {22'h000000, last_analog_ff, last_copy_ff,
                               aflag_ff, dflag_ff}; // RULE5
      `REG_RAW_A: nxt_rdata = i_din_a; // RULE11
      `REG_RAW_B: nxt_rdata = i_din_b; // RULE11
      `REG_RAW_C: nxt_rdata = i_din_c; // RULE11
      `REG_ANA_AB: nxt_rdata = {i_ain_b, i_ain_a}; // RULE11
      `REG_ANA_C: nxt_rdata = {16'h0000, i_ain_c}; // RULE11
      `REG_VOTED_DI: nxt_rdata = o_voted_di;
      `REG_VOTED_AI: nxt_rdata = {16'h0000, o_voted_ai};
      `REG_LOGIC_OUT: nxt_rdata = logic_out_ff;
      `REG_NV_OUT: nxt_rdata = nv_out_ff;
      `REG_FT_OUT: nxt_rdata = ft_out_ff;
      `REG_PHYS_OUT: nxt_rdata = o_phys_out;
      default: nxt_rdata = 32'h00000000;
    endcase
  end

  wire wr_ctrl = wr_commit && i_address == `REG_CTRL;
  wire wr_fault = wr_commit && i_address == `REG_FAULT;
  wire [31:0] ctrl_new = bemask(ctrl_word, i_writedata, i_byteenable);
  wire [31:0] thr_new = bemask({25'h0, thresh_ff}, i_writedata,
                               i_byteenable);
  wire [31:0] adef_new = bemask({16'h0, ana_def_ff}, i_writedata,
                                i_byteenable);
  wire [5:0] fclr = (wr_fault && i_byteenable[0]) ? i_writedata[5:0] :
                    6'h00;

  // ----------------------------------------------------------------
  // avalon slave and configuration
  // ----------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      o_waitrequest <= 1'b1;
      o_readdata <= 32'h00000000;
      ctrl_ff <= `CTRL_RST;
      def_in_ff <= `DEF_IN_RST;
      ana_def_ff <= `ANA_DEF_RST;
      thresh_ff <= `THRESH_RST;
      interval_ff <= `INTERVAL_MS_RST; // RULE15
      logic_out_ff <= 32'h00000000;
      nv_out_ff <= 32'h00000000;
    end
    else
    begin
      // one wait state: ready one edge after the request is seen
      o_waitrequest <= ~(bus_req & o_waitrequest);
      if (rd_launch)
        o_readdata <= nxt_rdata;
      if (wr_ctrl)
        ctrl_ff <= ctrl_new[`CTRL_WIDTH-1:0]; // RULE16
      if (wr_commit && i_address == `REG_DEF_IN)
        def_in_ff <= bemask(def_in_ff, i_writedata, i_byteenable);
      if (wr_commit && i_address == `REG_ANA_DEF)
        ana_def_ff <= adef_new[15:0];
      if (wr_commit && i_address == `REG_THRESH)
        thresh_ff <= thr_new[6:0];
      if (wr_commit && i_address == `REG_INTERVAL)
        interval_ff <= bemask(interval_ff, i_writedata,
                              i_byteenable); // RULE15
      if (wr_commit && i_address == `REG_LOGIC_OUT)
        logic_out_ff <= bemask(logic_out_ff, i_writedata, i_byteenable);
      if (wr_commit && i_address == `REG_NV_OUT)
        nv_out_ff <= bemask(nv_out_ff, i_writedata, i_byteenable);
    end
  end

  // ----------------------------------------------------------------
  // voting, fault log and staging
  // ----------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      dflag_ff <= 3'h0; // RULE21
      aflag_ff <= 3'h0; // RULE21
      last_copy_ff <= 3'h0;
      last_analog_ff <= 1'b0;
      o_voted_di <= 32'h00000000; // RULE21
      o_voted_ai <= 16'h0000; // RULE21
      o_vote_done <= 1'b0;
      ft_out_ff <= 32'h00000000;
      o_phys_out <= 32'h00000000; // RULE21
      o_tx_nonvoted <= 32'h00000000;
      o_tx_ft <= 32'h00000000;
      o_tx_valid <= 1'b0;
    end
    else
    begin
      // a new discrepancy wins over a clear in the same cycle
      dflag_ff <= (dflag_ff & ~fclr[2:0]) | dset; // RULE5 RULE6
      aflag_ff <= (aflag_ff & ~fclr[5:3]) | aset; // RULE5 RULE6
      if (|aset)
      begin
        last_copy_ff <= aset; // RULE5
        last_analog_ff <= 1'b1;
      end
      if (|dset)
      begin
        last_copy_ff <= dset; // RULE5
        last_analog_ff <= 1'b0;
      end
      o_vote_done <= i_cycle_start; // RULE11
      if (i_cycle_start)
      begin
        o_voted_di <= nxt_voted_di; // RULE11
        o_voted_ai <= nxt_voted_ai; // RULE11
        ft_out_ff <= o_shutdown_active ? 32'h0 : logic_out_ff; // RULE12
      end
      o_phys_out <= nxt_phys;
      o_tx_valid <= i_bus_scan;
      if (i_bus_scan)
      begin
        o_tx_nonvoted <= nv_out_ff; // RULE13
        o_tx_ft <= ft_out_ff; // RULE13
      end
    end
  end

  // ----------------------------------------------------------------
  // shutdown sequencing
  // ----------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      tick_cnt_ff <= 32'h00000000;
      sd_cnt_ff <= 32'h00000000;
      o_shutdown_pending <= 1'b0; // RULE21
      o_shutdown_active <= 1'b0; // RULE21
    end
    else
    begin
      tick_cnt_ff <= (ms_tick || !any_fault) ? 32'h0 : tick_cnt_ff + 32'h1;
      if (!any_fault)
      begin
        sd_cnt_ff <= 32'h00000000;
        o_shutdown_pending <= 1'b0;
        o_shutdown_active <= 1'b0;
      end
      else
      begin
        o_shutdown_pending <= ~o_shutdown_active; // RULE16
        if (ms_tick && !sd_expired)
          sd_cnt_ff <= sd_cnt_ff + 32'h1; // RULE15
        if (sd_expired && !ctrl_ff[`CTRL_INHIBIT])
          o_shutdown_active <= 1'b1; // RULE14 RULE16
      end
    end
  end

endmodule // redundant_io_voter

`default_nettype wire

// [logic/io_voter_defs.vh]
// io_voter_defs.vh: register offsets, field positions, reset values and
// timing counts of the redundant i/o voter.
// assumes a 100 MHz clock and a 32-bit byte-addressed avalon slave.
`ifndef IO_VOTER_DEFS_VH
`define IO_VOTER_DEFS_VH

// byte addresses of the registers
`define REG_CTRL      7'h00
`define REG_DEF_IN    7'h04
`define REG_ANA_DEF   7'h08
`define REG_THRESH    7'h0C
`define REG_INTERVAL  7'h10
`define REG_STATUS    7'h14
`define REG_FAULT     7'h18
`define REG_RAW_A     7'h1C
`define REG_RAW_B     7'h20
`define REG_RAW_C     7'h24
`define REG_ANA_AB    7'h28
`define REG_ANA_C     7'h2C
`define REG_VOTED_DI  7'h30
`define REG_VOTED_AI  7'h34
`define REG_LOGIC_OUT 7'h38
`define REG_NV_OUT    7'h3C
`define REG_FT_OUT    7'h40
`define REG_PHYS_OUT  7'h44

// control register fields
`define CTRL_CHK_EN    0
`define CTRL_DEG_DEF   1
`define CTRL_AMODE_LO  2
`define CTRL_AMODE_HI  3
`define CTRL_OUT_2OF2  4
`define CTRL_ONE_DEF   5
`define CTRL_INHIBIT   6
`define CTRL_GRP32     7
`define CTRL_WIDTH     8

// two-copy analog selection
`define AMODE_HIGH 2'h0
`define AMODE_LOW  2'h1
`define AMODE_AVG  2'h2

// reset values
`define CTRL_RST     8'h01
`define DEF_IN_RST   32'h00000000
`define ANA_DEF_RST  16'h0000
`define THRESH_RST   7'h0A

// timing: autotest interval counted in milliseconds
`define CLK_HZ          100000000
`define TICK_MS         1
`define TICK_CYCLES     (`CLK_HZ / 1000 * `TICK_MS)
`define INTERVAL_MS_RST 32'h01B77400
`define SD_INTERVALS    3

`endif

// [verification/io_voter_checker.sv]
// io_voter_checker.sv: concurrent checks on the voter's ports.
// assumes it is bound into redundant_io_voter; one clock domain.
`timescale 1ns/1ns
`default_nettype none
module io_voter_checker #(
  parameter int TICK_CYCLES = 4
) (
  input wire logic i_clk,
  input wire logic i_resetn,
  input wire logic i_cycle_start,
  input wire logic i_bus_scan,
  input wire logic [2:0] i_copy_present,
  input wire logic [2:0] i_autotest_fault,
  input wire logic [2:0] i_block_fault,
  input wire logic [31:0] i_din_a,
  input wire logic [31:0] i_din_b,
  input wire logic [31:0] i_din_c,
  input wire logic [2:0] i_cmd_present,
  input wire logic [31:0] i_cmd_a,
  input wire logic [31:0] i_cmd_b,
  input wire logic [31:0] i_cmd_c,
  input wire logic o_waitrequest,
  input wire logic [31:0] o_voted_di,
  input wire logic o_vote_done,
  input wire logic o_tx_valid,
  input wire logic [31:0] o_phys_out,
  input wire logic o_shutdown_pending,
  input wire logic o_shutdown_active
);
  // ----------------------------------------------------------
  // properties
  // ----------------------------------------------------------
  function automatic logic [31:0] maj(logic [31:0] a, b, c);
    return (a & b) | (a & c) | (b & c);
  endfunction
  logic clean;
  assign clean = i_copy_present == 3'h7 && i_autotest_fault == 3'h0 &&
    i_block_fault == 3'h0 && !o_shutdown_pending && !o_shutdown_active;
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  chk_wait_once:
    assert property (!o_waitrequest |=> o_waitrequest)
    else $error("waitrequest low for more than one cycle");
  chk_reset_off:
    assert property ($rose(i_resetn) |-> o_phys_out == 32'h0 &&
      !o_shutdown_pending && !o_vote_done)
    else $error("outputs not safe after reset");
  chk_vote_done:
    assert property (i_cycle_start |=> o_vote_done)
    else $error("vote done missing after cycle start");
  chk_done_cause:
    assert property (o_vote_done |-> $past(i_cycle_start))
    else $error("vote done without cycle start");
  chk_disc_maj:
    assert property (i_cycle_start && clean |=> o_voted_di ==
      maj($past(i_din_a), $past(i_din_b), $past(i_din_c)))
    else $error("discrete vote is not the majority");
  chk_out_maj:
    assert property (i_cmd_present == 3'h7 |=> (o_phys_out &
      ~maj($past(i_cmd_a), $past(i_cmd_b), $past(i_cmd_c))) == 32'h0)
    else $error("output on without majority command");
  chk_tx_valid:
    assert property (i_bus_scan |=> o_tx_valid)
    else $error("scan not answered");
  chk_shut_off:
    assert property (o_shutdown_active && $past(o_shutdown_active) |->
      o_phys_out == 32'h0)
    else $error("outputs on during shutdown");
  chk_active_src:
    assert property ($rose(o_shutdown_active) |-> $past(o_shutdown_pending))
    else $error("shutdown without pending");
  chk_shut_delay:
    assert property ($rose(o_shutdown_pending) |=> !o_shutdown_active [*8])
    else $error("shutdown too soon after fault");
  cov_vote: cover property (i_cycle_start && clean);
  cov_shut: cover property ($rose(o_shutdown_active));
  cov_two_cmd: cover property (i_cmd_present == 3'h3 && o_phys_out != 32'h0);
endmodule // io_voter_checker
bind redundant_io_voter io_voter_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
  .i_clk, .i_resetn, .i_cycle_start, .i_bus_scan, .i_copy_present,
  .i_autotest_fault, .i_block_fault, .i_din_a, .i_din_b, .i_din_c,
  .i_cmd_present, .i_cmd_a, .i_cmd_b, .i_cmd_c, .o_waitrequest,
  .o_voted_di, .o_vote_done, .o_tx_valid, .o_phys_out,
  .o_shutdown_pending, .o_shutdown_active
);
`default_nettype wire

// [verification/field_side_model.sv]
// field_side_model.sv: field channels and controllers feeding the voter.
// assumes the bench sets copy values and which copies are served.
`timescale 1ns/1ns
`default_nettype none
module field_side_model (
  input wire logic [2:0] i_present,
  input wire logic [2:0] i_cmd_on,
  input wire logic [2:0][31:0] i_d,
  input wire logic [2:0][15:0] i_a,
  input wire logic [2:0][31:0] i_cmd,
  output logic [2:0][31:0] o_d,
  output logic [2:0][15:0] o_a,
  output logic [2:0][31:0] o_cmd
);
  // ----------------------------------------------------------
  // copies
  // ----------------------------------------------------------
  // an unserved copy carries the inverse, so a voter that uses it errs
  always_comb
  begin
    for (int k = 0; k < 3; k++)
    begin
      o_d[k] = i_present[k] ? i_d[k] : ~i_d[k];
      o_a[k] = i_present[k] ? i_a[k] : ~i_a[k];
      o_cmd[k] = i_cmd_on[k] ? i_cmd[k] : ~i_cmd[k];
    end
  end
endmodule // field_side_model
`default_nettype wire

// [verification/redundant_io_voter_tb.sv]
// redundant_io_voter_tb.sv: register-driven tests of the voter.
// assumes the checker is bound and a small tick count is set.
`timescale 1ns/1ns
`include "io_voter_defs.vh"
`default_nettype none
module redundant_io_voter_tb;
  // ----------------------------------------------------------
  // bench
  // ----------------------------------------------------------
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic [6:0] addr = 7'h00;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic cyc = 1'b0;
  logic scan = 1'b0;
  logic [31:0] wdata = 32'h0;
  logic [31:0] got;
  logic [2:0] pres = 3'h7;
  logic [2:0] atf = 3'h0;
  logic [2:0] cpres = 3'h7;
  logic [2:0][31:0] dv = {3{32'h600DF00D}};
  logic [2:0][15:0] av = {3{16'h00C8}};
  logic [2:0][31:0] cv = {32'hFFFF00AA, 32'hFFFF00CC, 32'hFFFF00F0};
  logic [2:0][31:0] din, cmd;
  logic [2:0][15:0] ain;
  logic [31:0] rdata, vdi, txn, txf, phys;
  logic [15:0] vai;
  logic wreq, vdone, txv, pend, act;
  int n_mismatch = 0;
  int checks = 0;
  always #5 clk = ~clk;
  redundant_io_voter #(.TICK_CYCLES(4)) i_dut (
    .i_clk(clk), .i_resetn(rst_n), .i_address(addr), .i_read(rd),
    .i_write(wr), .i_writedata(wdata), .i_byteenable(4'hF),
    .o_readdata(rdata), .o_waitrequest(wreq), .i_cycle_start(cyc),
    .i_bus_scan(scan), .i_copy_present(pres), .i_autotest_fault(atf),
    .i_block_fault(3'h0), .i_din_a(din[0]), .i_din_b(din[1]),
    .i_din_c(din[2]), .i_ain_a(ain[0]), .i_ain_b(ain[1]),
    .i_ain_c(ain[2]), .i_cmd_present(cpres), .i_cmd_a(cmd[0]),
    .i_cmd_b(cmd[1]), .i_cmd_c(cmd[2]), .o_voted_di(vdi),
    .o_voted_ai(vai), .o_vote_done(vdone), .o_tx_nonvoted(txn),
    .o_tx_ft(txf), .o_tx_valid(txv), .o_phys_out(phys),
    .o_shutdown_pending(pend), .o_shutdown_active(act)
  );
  field_side_model i_far (
    .i_present(pres), .i_cmd_on(cpres), .i_d(dv), .i_a(av), .i_cmd(cv),
    .o_d(din), .o_a(ain), .o_cmd(cmd)
  );
  task chk(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task acc(input logic w, input logic [6:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr <= w;
    rd <= ~w;
    do
      @(posedge clk);
    while (wreq !== 1'b0);
    got = rdata;
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task rdc(input logic [6:0] a, input logic [31:0] exp);
    acc(1'b0, a, 32'h0);
    chk(got, exp);
  endtask
  task vote(input logic [2:0] p, input logic [2:0] f);
    @(posedge clk);
    pres <= p;
    atf <= f;
    cyc <= 1'b1;
    @(posedge clk);
    cyc <= 1'b0;
    @(negedge clk);
  endtask
  task oc(input logic [2:0] p, input logic [7:0] c, input logic [31:0] e);
    acc(1'b1, `REG_CTRL, {24'h0, c});
    @(posedge clk);
    cpres <= p;
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk(phys, e);
  endtask
  task report_and_stop;
    $display("checks %0d mismatches %0d", checks, n_mismatch);
    if (n_mismatch == 0 && checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  initial
  begin
    #50000;
    n_mismatch++;
    report_and_stop;
  end
  initial
  begin
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rdc(`REG_CTRL, {24'h0, `CTRL_RST});
    rdc(`REG_THRESH, {25'h0, `THRESH_RST});
    chk(phys, 32'h0);
    acc(1'b1, 7'h48, 32'hFFFFFFFF);
    rdc(7'h48, 32'h0);
    for (int k = 0; k < 3; k++)
    begin
      @(posedge clk);
      dv <= {3{32'h5A5A0FF0}} ^ (96'hFFFFFFFF << (32 * k));
      vote(3'h7, 3'h0);
      chk({31'h0, vdone}, 32'h1);
      chk(vdi, 32'h5A5A0FF0);
      rdc(`REG_FAULT, 32'h41 << k);
      rdc(`REG_RAW_A + 7'(4 * k), 32'hA5A5F00F);
      acc(1'b1, `REG_FAULT, 32'h7);
    end
    acc(1'b1, `REG_DEF_IN, 32'h0F0F0F0F);
    @(posedge clk);
    dv <= {32'hC0DE0001, 32'h123456FF, 32'h12345600};
    vote(3'h3, 3'h0);
    chk(vdi, 32'h1234560F);
    vote(3'h5, 3'h0);
    chk(vdi, 32'h021E0601);
    vote(3'h4, 3'h0);
    chk(vdi, 32'hC0DE0001);
    for (int m = 0; m < 2; m++)
    begin
      acc(1'b1, `REG_CTRL, 32'h1 | (m << 1));
      vote(3'h7, 3'h3);
      chk(vdi, m ? 32'h0F0F0F0F : 32'hC0DE0001);
    end
    acc(1'b0, `REG_STATUS, 32'h0);
    chk(got & 32'hC7, 32'h44);
    acc(1'b1, `REG_CTRL, 32'h1);
    @(posedge clk);
    dv <= {3{32'h600DF00D}};
    av <= {16'h00C6, 16'h00CD, 16'h00C8};
    vote(3'h7, 3'h0);
    chk({16'h0, vai}, 32'h00C8);
    @(posedge clk);
    av[2] <= 16'h012C;
    vote(3'h7, 3'h0);
    chk({16'h0, vai}, 32'h00CD);
    rdc(`REG_FAULT, 32'h320);
    acc(1'b1, `REG_FAULT, 32'h38);
    for (int md = 0; md < 3; md++)
    begin
      acc(1'b1, `REG_CTRL, 32'h1 | (md << 2));
      vote(3'h3, 3'h0);
      chk({16'h0, vai}, md == 0 ? 32'hCD : md == 1 ? 32'hC8 : 32'hCA);
    end
    vote(3'h1, 3'h0);
    chk({16'h0, vai}, 32'h00C8);
    acc(1'b1, `REG_LOGIC_OUT, 32'hFFFFFFFF);
    vote(3'h7, 3'h0);
    rdc(`REG_FT_OUT, 32'hFFFFFFFF);
    oc(3'h7, 8'h01, 32'h000000E8);
    oc(3'h7, 8'h81, 32'hFFFF00E8);
    oc(3'h3, 8'h81, 32'hFFFF00FC);
    oc(3'h3, 8'h91, 32'hFFFF00C0);
    oc(3'h1, 8'h81, 32'hFFFF00F0);
    oc(3'h1, 8'hA1, 32'h0);
    acc(1'b1, `REG_NV_OUT, 32'h0000A5A5);
    acc(1'b1, `REG_LOGIC_OUT, 32'h3C3C3C3C);
    vote(3'h7, 3'h0);
    oc(3'h7, 8'h81, 32'h3C3C0028);
    @(posedge clk);
    scan <= 1'b1;
    @(posedge clk);
    scan <= 1'b0;
    @(negedge clk);
    chk(txn, 32'h0000A5A5);
    chk(txf, 32'h3C3C3C3C);
    acc(1'b1, `REG_INTERVAL, 32'h2);
    vote(3'h7, 3'h1);
    acc(1'b0, `REG_STATUS, 32'h0);
    chk((got >> 10) & 32'h3, 32'h1);
    repeat (12) @(posedge clk);
    chk({31'h0, act}, 32'h0);
    repeat (28) @(posedge clk);
    chk({31'h0, act}, 32'h1);
    vote(3'h7, 3'h1);
    chk(vdi, 32'h0F0F0F0F);
    chk(phys, 32'h0);
    vote(3'h7, 3'h0);
    chk({30'h0, pend, act}, 32'h0);
    acc(1'b1, `REG_CTRL, 32'hC1);
    vote(3'h7, 3'h1);
    repeat (50) @(posedge clk);
    chk({30'h0, pend, act}, 32'h2);
    vote(3'h7, 3'h0);
    report_and_stop;
  end
endmodule // redundant_io_voter_tb
`default_nettype wire
